// ---- tb.sv ----
/*
 Self-checking bench for ufl_top with line model and checker.
 Assumes a 40 MHz clock; random data from a fixed seed.
*/
`timescale 1ns/10ps
module tb;
    localparam int BIT = 352;
    localparam int TICK = 22;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_start = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] reg_rdata, rx_data, v;
    logic tx_busy, rx_valid, serial_in, serial_out, irq, irq_oe;
    logic terminal_ready_n, request_to_send_n;
    logic [3:0] stat_n;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int wl, st;
    always #12.5 clk = ~clk;
    ufl_top i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_start(tx_start), .tx_data(tx_data),
        .tx_busy(tx_busy), .rx_data(rx_data), .rx_valid(rx_valid),
        .serial_in(serial_in), .serial_out(serial_out),
        .clear_to_send_n(stat_n[0]), .set_ready_n(stat_n[1]),
        .ring_indicate_n(stat_n[2]), .carrier_detect_n(stat_n[3]),
        .terminal_ready_n(terminal_ready_n),
        .request_to_send_n(request_to_send_n), .irq(irq), .irq_oe(irq_oe));
    ufl_line i_line (.clk(clk), .line(serial_in), .stat_n(stat_n));
    task automatic wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    function automatic logic [7:0] wmask(input int w);
        return 8'hFF >> (3 - w);
    endfunction : wmask
    // Start, data, stop; 1.5 stop only for five bits
    function automatic int flen(input int w, input int s);
        return BIT * (w + 7) + (s == 0 ? 0 : (w == 0 ? BIT / 2 : BIT));
    endfunction : flen
    task automatic kick(input logic [7:0] d);
        @(posedge clk);
        tx_start <= 1'b1;
        tx_data <= d;
        @(posedge clk);
        tx_start <= 1'b0;
    endtask : kick
    task automatic rx_wait(input logic [7:0] e);
        int t;
        t = 0;
        while (rx_valid !== 1'b1 && t < 12 * BIT)
        begin
            @(posedge clk);
            t++;
        end
        chk(rx_data, e);
        @(posedge clk);
    endtask : rx_wait
    task automatic tx_chk(input logic [7:0] d, input int w, input int s);
        int t, i;
        kick(d);
        t = 0;
        while (serial_out !== 1'b0 && t < 50)
        begin
            @(posedge clk);
            t++;
        end
        repeat (BIT / 2) @(posedge clk);
        chk(8'(serial_out), 8'h00);
        for (i = 0; i < w + 5; i++)
        begin
            repeat (BIT) @(posedge clk);
            chk(8'(serial_out), 8'(d[i]));
        end
        repeat (BIT) @(posedge clk);
        chk(8'(serial_out), 8'h01);
        t = BIT * (w + 6) + BIT / 2;
        while (tx_busy === 1'b1 && t < flen(w, s) + 50)
        begin
            @(posedge clk);
            t++;
        end
        // Start bit waits for the first tick, so it may lose one tick
        chk(8'(t > flen(w, s) - TICK - 3 && t < flen(w, s) + 3),
            8'h01);
    endtask : tx_chk
    // Hang guard; the full run needs about 56000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            miscompares++;
            wrap_up;
        end
    end
    initial
    begin
        void'($urandom(32'hF69D));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(3'h4, 8'h00);
        chk(8'({terminal_ready_n, request_to_send_n, irq_oe}), 8'h06);
        wr(3'h4, 8'hEF);
        rd(3'h4, 8'h0F);
        rd(3'h5, 8'h00);
        repeat (4)
        begin
            v = 8'($urandom) & 8'hEF;
            wr(3'h4, v);
            rd(3'h4, v & 8'h0F);
            chk(8'({terminal_ready_n, request_to_send_n, irq_oe}),
                8'({~v[0], ~v[1], v[3]}));
        end
        wr(3'h4, 8'h00);
        for (wl = 0; wl < 4; wl++)
            for (st = 0; st < 2; st++)
            begin
                wr(3'h3, 8'(wl + 4 * st));
                tx_chk(8'($urandom), wl, st);
            end
        for (wl = 0; wl < 4; wl++)
        begin
            v = 8'($urandom);
            wr(3'h3, 8'(wl + 4));
            wr(3'h6, 8'h0F);
            fork
                begin
                    i_line.send(v, wl + 5, 2);
                    i_line.send(~v, wl + 5, 2);
                end
                begin
                    rx_wait(v & wmask(wl));
                    rx_wait(~v & wmask(wl));
                end
            join
            rd(3'h6, 8'h01);
        end
        // Sixth zero bit lands on the stop sample
        wr(3'h3, 8'h00);
        wr(3'h6, 8'h0F);
        fork
            i_line.send(8'h00, 6, 2);
            rx_wait(8'h00);
        join
        rd(3'h6, 8'h05);
        wr(3'h7, 8'h00);
        wr(3'h6, 8'h0F);
        i_line.blip(4'hE);
        rd(3'h6, 8'h08);
        chk(8'(irq), 8'h00);
        wr(3'h7, 8'h08);
        @(posedge clk);
        #1 chk(8'(irq), 8'h01);
        wr(3'h6, 8'h08);
        @(posedge clk);
        #1 chk(8'(irq), 8'h00);
        wr(3'h4, 8'h10);
        wr(3'h6, 8'h0F);
        i_line.blip(4'h0);
        rd(3'h6, 8'h00);
        wr(3'h4, 8'h13);
        rd(3'h6, 8'h08);
        chk(8'({terminal_ready_n, request_to_send_n}), 8'h03);
        wr(3'h6, 8'h0F);
        wr(3'h4, 8'h14);
        rd(3'h6, 8'h08);
        wr(3'h6, 8'h0F);
        wr(3'h7, 8'h01);
        wr(3'h3, 8'h03);
        v = 8'($urandom);
        fork
            i_line.noise(12 * BIT);
            begin
                kick(v);
                rx_wait(v);
            end
        join
        rd(3'h6, 8'h03);
        chk(8'(irq), 8'h01);
        wrap_up;
    end
endmodule : tb
bind ufl_top ufl_props i_props (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_out(serial_out),
    .terminal_ready_n(terminal_ready_n),
    .request_to_send_n(request_to_send_n), .irq(irq), .irq_oe(irq_oe));

// ---- ufl_defs.svh ----
/*
 Constants for the frame format and loopback block: register offsets,
 field positions, reset values and enables.
 Assumes inclusion by bare name from the modules.
*/
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH

`define UFL_OFF_LINE_FMT 3'h3
`define UFL_OFF_MODEM 3'h4
`define UFL_OFF_IRQ_STAT 3'h6
`define UFL_OFF_IRQ_MASK 3'h7
`define UFL_BIT_STOP 2
`define UFL_BIT_LOOP 4
`define UFL_BIT_GATE 3
`define UFL_MCR_MASK 8'h1F
`define UFL_RST_BYTE 8'h00
`define UFL_RST_MASK 4'h0
`define UFL_DIV_COUNT 16'h0015
`define UFL_BIT_TICKS 5'h10
`define UFL_HALF_TICKS 5'h08
`define UFL_TICK_LAST 4'hF
`define UFL_TICK_MID 4'h7

`endif

// ---- ufl_line.sv ----
/*
 Line-side model: terminal or modem driving receive line and status pins.
 Assumes callers run clock-synchronous; idle line has a pull-up to mark.
*/
`timescale 1ns/10ps
module ufl_line
(
    // Clock
    input wire logic clk,
    // Line towards the port
    output logic line,
    // Modem status, active low
    output logic [3:0] stat_n
);
    localparam int BIT = 352;
    initial
    begin
        line = 1'b1;
        stat_n = 4'hF;
    end
    // One character, stop length in half bits
    task automatic send(input logic [7:0] d, input int n, input int halfs);
        int i;
        @(posedge clk);
        line <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (i = 0; i < n; i++)
        begin
            line <= d[i];
            repeat (BIT) @(posedge clk);
        end
        line <= 1'b1;
        repeat (halfs * BIT / 2) @(posedge clk);
    endtask : send
    // Toggles every cycle so an ignored pin never looks quiet
    task automatic noise(input int n);
        repeat (n)
        begin
            @(posedge clk);
            line <= ~line;
        end
        @(posedge clk);
        line <= 1'b1;
    endtask : noise
    task automatic blip(input logic [3:0] v);
        @(posedge clk);
        stat_n <= v;
        repeat (4) @(posedge clk);
        stat_n <= 4'hF;
    endtask : blip
endmodule : ufl_line

// ---- ufl_pkg.sv ----
/*
 Types shared by the frame format and loopback block.
 Assumes ufl_defs.svh sits beside it.
*/
package ufl_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_STOP = 5'h08,
        TX_STOP2 = 5'h10
    } ufl_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } ufl_rx_state_t;

    // Width field to bit count: 00 five .. 11 eight
    function automatic logic [3:0] ufl_bits(input logic [1:0] wl);
        ufl_bits = 4'h5 + {2'h0, wl};
    endfunction : ufl_bits
endpackage : ufl_pkg

// ---- ufl_props.sv ----
/*
 Checker for the frame format and loopback slice.
 Sees only top ports; bound to ufl_top from the bench top file.
*/
`timescale 1ns/10ps
module ufl_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic serial_out,
    input wire logic terminal_ready_n,
    input wire logic request_to_send_n,
    input wire logic irq,
    input wire logic irq_oe
);
    logic [7:0] mcr_ff;
    logic [3:0] mask_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Shadows from bus writes; never read back from the design
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mcr_ff <= 8'h00;
            mask_ff <= 4'h0;
        end
        else if (reg_wr && reg_addr == 3'h4)
            mcr_ff <= reg_wdata & 8'h1F;
        else if (reg_wr && reg_addr == 3'h7)
            mask_ff <= reg_wdata[3:0];
    end
    AST_LOOP_MARK: assert property (
        mcr_ff[4] && $past(mcr_ff[4]) |-> serial_out)
        else $error("line left mark in loopback");
    AST_LOOP_PINS: assert property (
        $rose(mcr_ff[4]) |=> (terminal_ready_n && request_to_send_n) [*4])
        else $error("modem pins active in loopback");
    AST_LOOP_HOLD: assert property (
        mcr_ff[4] && $past(mcr_ff[4]) |->
        terminal_ready_n && request_to_send_n)
        else $error("modem pins not high in loopback");
    AST_READY_PIN: assert property (
        $stable(mcr_ff) && !mcr_ff[4] |-> terminal_ready_n == !mcr_ff[0])
        else $error("ready pin not inverse of bit 0");
    AST_SEND_PIN: assert property (
        $stable(mcr_ff) && !mcr_ff[4] |-> request_to_send_n == !mcr_ff[1])
        else $error("send pin not inverse of bit 1");
    AST_IRQ_GATE: assert property (
        $stable(mcr_ff) |-> irq_oe == mcr_ff[3])
        else $error("irq enable does not follow bit 3");
    AST_MCR_READ: assert property (
        $past(reg_rd) && $past(reg_addr) == 3'h4 |->
        reg_rdata == $past(mcr_ff))
        else $error("modem control read wrong");
    AST_IDLE_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_MASK_QUIET: assert property (
        $stable(mask_ff) && mask_ff == 4'h0 |-> !irq)
        else $error("irq with all sources masked");
endmodule : ufl_props

// ---- ufl_rx.sv ----
/*
 Serial receiver shift path; checks only the first stop bit.
 Assumes a 16x oversample enable pulse from the parent.
*/
`timescale 1ns/10ps
`include "ufl_defs.svh"
module ufl_rx
    import ufl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic tick,
    input wire logic ser_in,
    input wire logic [1:0] wlen,
    // Result
    output logic [7:0] data,
    output logic valid,
    output logic frame_err
);
    typedef struct packed {
        ufl_rx_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [3:0] tk;
        logic valid;
        logic ferr;
    } ufl_rx_reg_t;

    ufl_rx_reg_t r_ff, nxt_r;

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.valid = 1'b0;
        if (tick)
            nxt_r.tk = r_ff.tk + 4'h1;
        case (r_ff.st)
            RX_IDLE:
            begin
                nxt_r.tk = 4'h0;
                if (tick && !ser_in)
                    nxt_r.st = RX_START;
            end
            RX_START:
                if (tick && r_ff.tk == `UFL_TICK_MID)
                begin
                    nxt_r.tk = 4'h0;
                    nxt_r.cnt = 4'h0;
                    nxt_r.st = ser_in ? RX_IDLE : RX_DATA;
                end
            RX_DATA:
                if (tick && r_ff.tk == `UFL_TICK_LAST)
                begin
                    nxt_r.sh = {ser_in, r_ff.sh[7:1]};
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                    if (r_ff.cnt + 4'h1 == ufl_bits(wlen))
                        nxt_r.st = RX_STOP;
                end
            RX_STOP:
                // Later stop bits fall into idle and are never checked
                if (tick && r_ff.tk == `UFL_TICK_LAST)
                begin
                    nxt_r.st = RX_IDLE;
                    nxt_r.valid = 1'b1;
                    nxt_r.ferr = !ser_in;
                end
            default:
                nxt_r.st = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            r_ff <= '{st: RX_IDLE, sh: 8'h00, cnt: 4'h0, tk: 4'h0,
                      valid: 1'b0, ferr: 1'b0};
        else
            r_ff <= nxt_r;

    // Align short characters to bit 0
    assign data = r_ff.sh >> (4'h8 - ufl_bits(wlen));
    assign valid = r_ff.valid;
    assign frame_err = r_ff.ferr;
endmodule : ufl_rx

// ---- ufl_top.sv ----
/*
 Frame format, modem control and loopback slice of a serial port,
 with register port, event status, mask and gated interrupt.
 Assumes a synchronous register master and synchronous pin inputs.
*/
`timescale 1ns/10ps
`include "ufl_defs.svh"
// Operation
// - stop-select 0 sends one stop; 1 sends 1.5 (five bits) or two.
// - receiver checks only the first stop bit, ignores more.
// - size field 00..11 selects five to eight data bits.
// - loopback holds serial transmit output at mark.
// - loopback ignores receive pin, feeds transmit stream into receiver.
// - loopback disconnects the four external modem status inputs.
// - loopback routes ready, send, user a, user b to status inputs.
// - loopback drives all modem control pins inactive high.
// - receive and transmit interrupts work unchanged in loopback.
// - loopback modem interrupts come from low four control bits.
// - interrupt enables still gate every source in loopback.
// - user output b low disables the interrupt pin; high enables.
// - control bit 0 drives terminal ready pin inverted.
// - user output a is a plain bit with no pin.
module ufl_top
    import ufl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Transmit request
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    output logic tx_busy,
    // Receive result
    output logic [7:0] rx_data,
    output logic rx_valid,
    // Serial line
    input wire logic serial_in,
    output logic serial_out,
    // Modem pins
    input wire logic clear_to_send_n,
    input wire logic set_ready_n,
    input wire logic ring_indicate_n,
    input wire logic carrier_detect_n,
    output logic terminal_ready_n,
    output logic request_to_send_n,
    // Interrupt pin
    output logic irq,
    output logic irq_oe
);
    typedef struct packed {
        logic [7:0] line_fmt;
        logic [4:0] modem;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [3:0] msr_prev;
        logic [15:0] div;
        logic tick;
        logic [7:0] rdata;
        logic ser_out;
        logic dtr_n;
        logic rts_n;
        logic irq;
        logic irq_oe;
        logic [7:0] rx_data;
        logic rx_valid;
        logic tx_busy;
    } ufl_top_reg_t;

    ufl_top_reg_t r_ff, nxt_r;

    logic loop;
    logic tx_line;
    logic tx_busy_w;
    logic tx_done;
    logic rx_line;
    logic [7:0] rx_byte;
    logic rx_done;
    logic rx_ferr;
    logic [3:0] msr_now;
    logic [3:0] ev;

    assign loop = r_ff.modem[`UFL_BIT_LOOP];
    assign rx_line = loop ? tx_line : serial_in;

    // Status order {carrier, ring, ready, send}, all active high
    always_comb
    begin
        if (loop)
            msr_now = {r_ff.modem[3], r_ff.modem[2], r_ff.modem[0],
                       r_ff.modem[1]};
        else
            msr_now = {~carrier_detect_n, ~ring_indicate_n, ~set_ready_n,
                       ~clear_to_send_n};
    end

    // Event bits: 0 rx done, 1 tx done, 2 frame error, 3 modem change
    assign ev = {(msr_now != r_ff.msr_prev), rx_ferr & rx_done, tx_done,
                 rx_done};

    ufl_tx u_tx (
        .clk(clk),
        .rst_b(rst_b),
        .tick(r_ff.tick),
        .start(tx_start),
        .data(tx_data),
        .wlen(r_ff.line_fmt[1:0]),
        .two_stop(r_ff.line_fmt[`UFL_BIT_STOP]),
        .ser_out(tx_line),
        .busy(tx_busy_w),
        .done(tx_done)
    );

    ufl_rx u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .tick(r_ff.tick),
        .ser_in(rx_line),
        .wlen(r_ff.line_fmt[1:0]),
        .data(rx_byte),
        .valid(rx_done),
        .frame_err(rx_ferr)
    );

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tick = 1'b0;
        if (r_ff.div == `UFL_DIV_COUNT)
        begin
            nxt_r.div = 16'h0000;
            nxt_r.tick = 1'b1;
        end
        else
            nxt_r.div = r_ff.div + 16'h0001;
        nxt_r.msr_prev = msr_now;
        nxt_r.rdata = 8'h00;
        if (reg_wr)
        begin
            if (reg_addr == `UFL_OFF_LINE_FMT)
                nxt_r.line_fmt = reg_wdata;
            else if (reg_addr == `UFL_OFF_MODEM)
                nxt_r.modem = reg_wdata[4:0];
            else if (reg_addr == `UFL_OFF_IRQ_STAT)
                nxt_r.stat = r_ff.stat & ~reg_wdata[3:0];
            else if (reg_addr == `UFL_OFF_IRQ_MASK)
                nxt_r.mask = reg_wdata[3:0];
        end
        // Set wins over a clear in the same cycle
        nxt_r.stat = nxt_r.stat | ev;
        if (reg_rd)
        begin
            if (reg_addr == `UFL_OFF_LINE_FMT)
                nxt_r.rdata = r_ff.line_fmt;
            else if (reg_addr == `UFL_OFF_MODEM)
                nxt_r.rdata = {3'h0, r_ff.modem};
            else if (reg_addr == `UFL_OFF_IRQ_STAT)
                nxt_r.rdata = {4'h0, r_ff.stat};
            else if (reg_addr == `UFL_OFF_IRQ_MASK)
                nxt_r.rdata = {4'h0, r_ff.mask};
        end
        // Same edge as the loop bit, so no active pin slips out
        nxt_r.ser_out = nxt_r.modem[`UFL_BIT_LOOP] ? 1'b1 : tx_line;
        nxt_r.dtr_n = nxt_r.modem[`UFL_BIT_LOOP] ? 1'b1 :
            ~nxt_r.modem[0];
        nxt_r.rts_n = nxt_r.modem[`UFL_BIT_LOOP] ? 1'b1 :
            ~nxt_r.modem[1];
        // Mask applies regardless of loopback
        nxt_r.irq = |(nxt_r.stat & nxt_r.mask);
        // No tristate here; the pad uses the enable
        nxt_r.irq_oe = nxt_r.modem[`UFL_BIT_GATE];
        nxt_r.rx_valid = rx_done;
        if (rx_done)
            nxt_r.rx_data = rx_byte;
        nxt_r.tx_busy = tx_busy_w | tx_start;
    end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            r_ff <= '{line_fmt: `UFL_RST_BYTE, modem: 5'h00,
                      stat: `UFL_RST_MASK, mask: `UFL_RST_MASK,
                      msr_prev: 4'h0, div: 16'h0000, tick: 1'b0,
                      rdata: 8'h00, ser_out: 1'b1, dtr_n: 1'b1,
                      rts_n: 1'b1, irq: 1'b0, irq_oe: 1'b0,
                      rx_data: 8'h00, rx_valid: 1'b0, tx_busy: 1'b0};
        else
            r_ff <= nxt_r;

    assign reg_rdata = r_ff.rdata;
    assign serial_out = r_ff.ser_out;
    assign terminal_ready_n = r_ff.dtr_n;
    assign request_to_send_n = r_ff.rts_n;
    assign irq = r_ff.irq;
    assign irq_oe = r_ff.irq_oe;
    assign rx_data = r_ff.rx_data;
    assign rx_valid = r_ff.rx_valid;
    assign tx_busy = r_ff.tx_busy;
endmodule : ufl_top

// ---- ufl_tx.sv ----
/*
 Serial transmitter shift path with framing choices.
 Assumes a 16x oversample enable pulse from the parent.
*/
`timescale 1ns/10ps
`include "ufl_defs.svh"
module ufl_tx
    import ufl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic tick,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic [1:0] wlen,
    input wire logic two_stop,
    // Line and status
    output logic ser_out,
    output logic busy,
    output logic done
);
    typedef struct packed {
        ufl_tx_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [4:0] tk;
        logic [4:0] stop_len;
        logic out;
        logic done;
    } ufl_tx_reg_t;

    ufl_tx_reg_t r_ff, nxt_r;

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (tick)
            nxt_r.tk = r_ff.tk + 5'h01;
        case (r_ff.st)
            TX_IDLE:
            begin
                nxt_r.out = 1'b1;
                nxt_r.tk = 5'h00;
                if (start)
                begin
                    nxt_r.sh = data;
                    nxt_r.st = TX_START;
                    nxt_r.out = 1'b0;
                    nxt_r.cnt = 4'h0;
                    // Extra stop: half a bit for five bits, else whole
                    nxt_r.stop_len = (wlen == 2'b00) ?
                        `UFL_HALF_TICKS : `UFL_BIT_TICKS;
                end
            end
            TX_START, TX_DATA:
                if (tick && r_ff.tk == `UFL_BIT_TICKS - 5'h01)
                begin
                    nxt_r.tk = 5'h00;
                    if (r_ff.cnt == ufl_bits(wlen))
                    begin
                        nxt_r.st = TX_STOP;
                        nxt_r.out = 1'b1;
                    end
                    else
                    begin
                        nxt_r.st = TX_DATA;
                        nxt_r.out = r_ff.sh[0];
                        nxt_r.sh = {1'b0, r_ff.sh[7:1]};
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end
                end
            TX_STOP:
                if (tick && r_ff.tk == `UFL_BIT_TICKS - 5'h01)
                begin
                    nxt_r.tk = 5'h00;
                    if (two_stop)
                        nxt_r.st = TX_STOP2;
                    else
                    begin
                        nxt_r.st = TX_IDLE;
                        nxt_r.done = 1'b1;
                    end
                end
            TX_STOP2:
                if (tick && r_ff.tk == r_ff.stop_len - 5'h01)
                begin
                    nxt_r.st = TX_IDLE;
                    nxt_r.done = 1'b1;
                end
            default:
                nxt_r.st = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            r_ff <= '{st: TX_IDLE, sh: 8'h00, cnt: 4'h0, tk: 5'h00,
                      stop_len: 5'h00, out: 1'b1, done: 1'b0};
        else
            r_ff <= nxt_r;

    assign ser_out = r_ff.out;
    assign busy = (r_ff.st != TX_IDLE);
    assign done = r_ff.done;
endmodule : ufl_tx
